/* File: hw/adc_ctrl_pkg.sv */
package adc_ctrl_pkg;

	// Peripheral and register-file addresses
	localparam logic [7:0] REF_CODE_PADDR   = 8'h02;
	localparam logic [7:0] SEL_CMP_RFADDR   = 8'h21;

	// Field positions inside the register-file nibble at the compare address
	localparam int CMP_FLAG_BIT  = 0;
	localparam int CHAN_SEL_LSB  = 1;
	localparam int CHAN_SEL_MSB  = 3;

	// Widths
	localparam int CODE_W   = 4;
	localparam int CHAN_W   = 3;
	localparam int NSHARED  = 5;
	localparam int NPORTD   = 4;

	// Reset value of the channel select (dedicated input)
	localparam logic [2:0] CHAN_SEL_RST = 3'h0;
	// Power-on value of the reference code, nominally undefined
	localparam logic [3:0] REF_CODE_POR = 4'h0;
	// High data buffer nibble returned by a reference code read
	localparam logic [3:0] BUF_HIGH_READ = 4'h0;

	// Channel select encodings
	localparam logic [2:0] CH_DEDICATED = 3'h0;
	localparam logic [2:0] CH_PORTC_B3  = 3'h1;
	localparam logic [2:0] CH_PORTD_B0  = 3'h2;
	localparam logic [2:0] CH_NONE      = 3'h6;
	localparam logic [2:0] CH_FORBIDDEN = 3'h7;

	// Reference tap: 0 gives ground, n gives (2n-1)/32 of supply
	localparam int TAP_W = 5;

	// Conversion timing figures for software
	localparam int CONV_STEPS      = 17;
	localparam int CONV_TIME_US    = 34;
	localparam int CONV_TIME_DMA_US = 204;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} periph_req_s;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [3:0] wdata;
	} rf_req_s;

endpackage : adc_ctrl_pkg

/* File: hw/ref_tap_decode.sv */
`timescale 1ns/1ps
// Maps the reference code onto the resistor-string tap (units of supply/32)
module ref_tap_decode (
	input  wire logic [3:0] code_i,
	output logic      [4:0] tap_o
);
	always_comb begin
		if (code_i == 4'h0) begin
			tap_o = 5'h00;
		end else begin
			tap_o = {code_i, 1'b0} - 5'h01;
		end
	end
endmodule : ref_tap_decode

/* File: hw/sar_adc_control_logic.sv */
`timescale 1ns/1ps
// Behaviour
// - Code zero drives the comparator reference at ground.
// - Nonzero code n gives reference of supply times (2n-1)/32.
// - Four-bit reference code register lives at peripheral address 02H.
// - Reading the code returns it low, zeros in the high nibble.
// - Writing the code takes the low nibble, high nibble ignored.
// - Code undefined at power-on, kept through clock stop and chip-enable reset.
// - Compare flag is read-only bit 0 of register file 21H.
// - Flag is 1 when input at or above reference, else 0.
// - Reading 21H gives flag low and channel select in upper bits.
// - Select: 0 dedicated, 1-5 shared pins, 6 none, 7 forbidden.
// - Port D pull-down is removed while that pin is selected.
// - Port read of a selected shared pin returns 0.
module sar_adc_control_logic (
	input  wire logic                       sys_clk_i,
	input  wire logic                       resetn_i,
	input  wire logic                       ce_resetn_i,
	input  wire logic                       power_on_i,
	input  wire adc_ctrl_pkg::periph_req_s  periph_req_i,
	input  wire adc_ctrl_pkg::rf_req_s      rf_req_i,
	input  wire logic                       comp_out_i,
	input  wire logic                       portc_b3_pin_i,
	input  wire logic [3:0]                 portd_pin_i,
	output logic      [7:0]                 periph_rdata_o,
	output logic                            periph_rvalid_o,
	output logic      [3:0]                 rf_rdata_o,
	output logic                            rf_rvalid_o,
	output logic      [4:0]                 ref_tap_o,
	output logic      [2:0]                 mux_sel_o,
	output logic                            mux_none_o,
	output logic      [3:0]                 portd_pulldown_en_o,
	output logic                            portc_b3_rd_o,
	output logic      [3:0]                 portd_rd_o,
	output logic      [3:0]                 dac_reference_code_o
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} cmp_state_e;

	logic [3:0] dac_reference_code_q;
	logic [2:0] input_channel_select_q;
	logic       cmp_meta_q;
	logic       cmp_sync_q;
	logic       compare_result_flag;
	logic [4:0] tap_d;
	logic [4:0] pc_meta_q;
	logic [4:0] pc_sync_q;
	logic       ref_wr;
	logic       ref_rd;
	logic       sel_wr;
	logic       sel_rd;
	cmp_state_e cmp_state_q;

	assign ref_wr = periph_req_i.wr &&
		(periph_req_i.addr == adc_ctrl_pkg::REF_CODE_PADDR);
	assign ref_rd = periph_req_i.rd &&
		(periph_req_i.addr == adc_ctrl_pkg::REF_CODE_PADDR);
	assign sel_wr = rf_req_i.wr &&
		(rf_req_i.addr == adc_ctrl_pkg::SEL_CMP_RFADDR);
	assign sel_rd = rf_req_i.rd &&
		(rf_req_i.addr == adc_ctrl_pkg::SEL_CMP_RFADDR);

	// Only a power-on clears the code; the general and chip-enable resets
	// leave it alone so a conversion survives them.
	always_ff @(posedge sys_clk_i) begin
		if (power_on_i) begin
			dac_reference_code_q <= adc_ctrl_pkg::REF_CODE_POR;
		end else if (ref_wr) begin
			dac_reference_code_q <= periph_req_i.wdata[3:0];
		end
	end

	// The no-pin flag is set beside the select itself, so both change on
	// the same edge and a reader never sees them disagree.
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			input_channel_select_q <= adc_ctrl_pkg::CHAN_SEL_RST;
			mux_none_o             <= 1'b0;
		end else if (sel_wr) begin
			input_channel_select_q <= rf_req_i.wdata[
				adc_ctrl_pkg::CHAN_SEL_MSB:adc_ctrl_pkg::CHAN_SEL_LSB];
			mux_none_o <= (rf_req_i.wdata[3:2] == 2'b11);
		end
	end

	// Both registers are flip-flops already; a second stage would only
	// delay the mux and the code copy by one instruction clock.
	assign mux_sel_o            = input_channel_select_q;
	assign dac_reference_code_o = dac_reference_code_q;

	ref_tap_decode u_tap (
		.code_i (dac_reference_code_q),
		.tap_o  (tap_d)
	);

	// Tap is registered; the analog comparator settles well within one
	// instruction, and the flag is sampled through a two-stage synchroniser.
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			ref_tap_o <= 5'h00;
		end else begin
			ref_tap_o <= tap_d;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			cmp_meta_q <= 1'b0;
			cmp_sync_q <= 1'b0;
		end else begin
			cmp_meta_q <= comp_out_i;
			cmp_sync_q <= cmp_meta_q;
		end
	end

	// Comparator high means input at or above reference
	assign compare_result_flag = cmp_sync_q;

	// Marks one busy cycle after a code write; only unused_ce reads it, and flag reads do not wait on it
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			cmp_state_q <= ST_IDLE;
		end else begin
			case (cmp_state_q)
				ST_IDLE: begin
					if (ref_wr) begin
						cmp_state_q <= ST_BUSY;
					end
				end
				ST_BUSY: begin
					cmp_state_q <= ST_IDLE;
				end
				default: begin
					cmp_state_q <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			periph_rdata_o  <= 8'h00;
			periph_rvalid_o <= 1'b0;
		end else begin
			periph_rvalid_o <= ref_rd;
			if (ref_rd) begin
				periph_rdata_o <= {adc_ctrl_pkg::BUF_HIGH_READ,
					dac_reference_code_q};
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			rf_rdata_o  <= 4'h0;
			rf_rvalid_o <= 1'b0;
		end else begin
			rf_rvalid_o <= sel_rd;
			if (sel_rd) begin
				rf_rdata_o <= {input_channel_select_q,
					compare_result_flag};
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			pc_meta_q <= 5'h00;
			pc_sync_q <= 5'h00;
		end else begin
			pc_meta_q <= {portd_pin_i, portc_b3_pin_i};
			pc_sync_q <= pc_meta_q;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			portc_b3_rd_o <= 1'b0;
		end else begin
			portc_b3_rd_o <= (input_channel_select_q ==
				adc_ctrl_pkg::CH_PORTC_B3) ? 1'b0 : pc_sync_q[0];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < adc_ctrl_pkg::NPORTD; gi++) begin : g_portd
			logic hit;
			assign hit = (input_channel_select_q ==
				adc_ctrl_pkg::CH_PORTD_B0 + 3'(gi));
			always_ff @(posedge sys_clk_i) begin
				if (!resetn_i) begin
					portd_pulldown_en_o[gi] <= 1'b1;
					portd_rd_o[gi]          <= 1'b0;
				end else begin
					portd_pulldown_en_o[gi] <= !hit;
					portd_rd_o[gi] <= hit ? 1'b0 : pc_sync_q[gi+1];
				end
			end
		end
	endgenerate

	logic unused_ce;
	assign unused_ce = ce_resetn_i ^ (cmp_state_q == ST_BUSY);

endmodule : sar_adc_control_logic

/* File: sim/adc_ctrl_checker.sv */
`timescale 1ns/1ps
module adc_ctrl_checker (
	input wire logic                      sys_clk_i,
	input wire logic                      resetn_i,
	input wire logic                      power_on_i,
	input wire adc_ctrl_pkg::periph_req_s periph_req_i,
	input wire adc_ctrl_pkg::rf_req_s     rf_req_i,
	input wire logic [7:0]                periph_rdata_o,
	input wire logic                      periph_rvalid_o,
	input wire logic [3:0]                rf_rdata_o,
	input wire logic [4:0]                ref_tap_o,
	input wire logic [2:0]                mux_sel_o,
	input wire logic [3:0]                portd_pulldown_en_o,
	input wire logic                      portc_b3_rd_o,
	input wire logic [3:0]                dac_reference_code_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	logic       prd, pwr, rrd, rwr;
	logic [3:0] pd_exp;
	assign prd = periph_req_i.rd && periph_req_i.addr == 8'h02;
	assign pwr = periph_req_i.wr && periph_req_i.addr == 8'h02;
	assign rrd = rf_req_i.rd && rf_req_i.addr == 8'h21;
	assign rwr = rf_req_i.wr && rf_req_i.addr == 8'h21;
	// Only port D pins (select 2 to 5) lose their pull-down
	assign pd_exp = (mux_sel_o inside {[3'h2:3'h5]}) ?
		~(4'h1 << (mux_sel_o - 3'h2)) : 4'hf;
	rd_valid_a: assert property (prd |=> periph_rvalid_o)
		else $error("code read gave no valid");
	stray_valid_a: assert property (!prd |=> !periph_rvalid_o)
		else $error("valid without code read");
	rd_data_a: assert property (prd && !pwr |=>
		periph_rdata_o == {4'h0, $past(dac_reference_code_o)})
		else $error("code read data wrong");
	wr_code_a: assert property (pwr && !power_on_i |=>
		dac_reference_code_o == $past(periph_req_i.wdata[3:0]))
		else $error("code write not taken");
	code_hold_a: assert property (!pwr && !power_on_i |=>
		$stable(dac_reference_code_o)) else $error("code changed");
	tap_map_a: assert property ($past(resetn_i) |-> ref_tap_o ==
		($past(dac_reference_code_o) == 4'h0 ? 5'h0 :
		{$past(dac_reference_code_o), 1'b0} - 5'h1))
		else $error("tap mismatch");
	sel_write_a: assert property (rwr |=>
		mux_sel_o == $past(rf_req_i.wdata[3:1])) else $error("select");
	sel_read_a: assert property (rrd && !rwr |=>
		rf_rdata_o[3:1] == $past(mux_sel_o)) else $error("select read");
	pull_down_a: assert property ($stable(mux_sel_o) |->
		portd_pulldown_en_o == pd_exp) else $error("pull-down wrong");
	portc_mask_a: assert property (mux_sel_o == 3'h1 &&
		$stable(mux_sel_o) |-> !portc_b3_rd_o) else $error("port c read");
endmodule : adc_ctrl_checker
bind sar_adc_control_logic adc_ctrl_checker u_chk (.sys_clk_i, .resetn_i,
	.power_on_i, .periph_req_i, .rf_req_i, .periph_rdata_o, .periph_rvalid_o,
	.rf_rdata_o, .ref_tap_o, .mux_sel_o, .portd_pulldown_en_o, .portc_b3_rd_o,
	.dac_reference_code_o);

/* File: sim/analog_front_model.sv */
`timescale 1ns/1ps
// Input mux and comparator; levels in units of supply/64
module analog_front_model (
	input wire logic [2:0]  sel_i,
	input wire logic [4:0]  tap_i,
	input wire logic [35:0] vin_i,
	output logic            comp_o
);
	logic [5:0] v;
	// Select 6 and 7 reach no pin: the open node is taken as ground
	assign v = (sel_i < 3'h6) ? vin_i[sel_i*6 +: 6] : 6'h0;
	assign comp_o = v >= {tap_i, 1'b0};
endmodule : analog_front_model

/* File: sim/sar_adc_control_logic_tb.sv */
`timescale 1ns/1ps
module sar_adc_control_logic_tb;
	logic sys_clk_i, resetn_i, ce_resetn_i, power_on_i, comp, pc, pv, rv, nn, pcr;
	adc_ctrl_pkg::periph_req_s preq;
	adc_ctrl_pkg::rf_req_s     rreq;
	logic [3:0]  pd, pdr, pde, cd, rfd, code, m;
	logic [7:0]  prd;
	logic [4:0]  tap;
	logic [2:0]  sel;
	logic [35:0] vin;
	int          mismatches, n_compared, cyc, c, b, e;
	sar_adc_control_logic u_dut (.sys_clk_i, .resetn_i, .ce_resetn_i,
		.power_on_i, .periph_req_i(preq), .rf_req_i(rreq), .comp_out_i(comp),
		.portc_b3_pin_i(pc), .portd_pin_i(pd), .periph_rdata_o(prd),
		.periph_rvalid_o(pv), .rf_rdata_o(rfd), .rf_rvalid_o(rv),
		.ref_tap_o(tap), .mux_sel_o(sel), .mux_none_o(nn),
		.portd_pulldown_en_o(pde), .portc_b3_rd_o(pcr), .portd_rd_o(pdr),
		.dac_reference_code_o(cd));
	analog_front_model u_afe (.sel_i(sel), .tap_i(tap), .vin_i(vin), .comp_o(comp));
	task chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task op(input bit rf, input bit wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		if (rf) rreq <= '{!wr, wr, a, d[3:0]};
		else preq <= '{!wr, wr, a, d};
		@(posedge sys_clk_i);
		preq <= '0;
		rreq <= '0;
		#1;
	endtask : op
	task wrap_up;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	initial begin
		sys_clk_i = 0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end
	// Whole run is near 270 cycles
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			wrap_up();
		end
	end
	initial begin
		{resetn_i, power_on_i, ce_resetn_i, pc, pd, vin} = {3'b011, 5'h1f, 36'h0};
		{preq, rreq} = '0;
		c = $urandom(32'h1957);
		repeat (4) @(posedge sys_clk_i);
		{resetn_i, power_on_i} <= 2'b10;
		op(0, 0, 8'h02, 8'h00);
		chk(prd, 8'h00, "code at power-on");
		for (c = 0; c < 16; c++) begin
			op(0, 1, 8'h02, {4'($urandom), 4'(c)});
			op(0, 0, 8'h02, 8'h00);
			chk(8'(pv), 8'h01, "code read valid");
			chk(prd, 8'(c), "code read");
			chk(tap, 8'(c == 0 ? 0 : 2 * c - 1), "tap");
		end
		op(0, 0, 8'h03, 8'h00);
		chk(pv, 0, "stray valid");
		@(posedge sys_clk_i);
		{ce_resetn_i, resetn_i} <= 2'b00;
		repeat (2) @(posedge sys_clk_i);
		{ce_resetn_i, resetn_i} <= 2'b11;
		op(0, 0, 8'h02, 8'h00);
		chk(prd, 8'h0f, "code kept");
		$display("test codes done");
		for (c = 0; c < 7; c++) begin
			e = c < 6 ? $urandom % 64 : 0;
			@(posedge sys_clk_i);
			if (c < 6) vin[c*6 +: 6] <= 6'(e);
			{pc, pd} <= 5'($urandom); // shared pins act as inputs
			// Flag bit written as 1 must not stick
			op(1, 1, 8'h21, {4'h0, 3'(c), 1'b1});
			code = 4'h0; // four write-and-test steps per conversion
			for (b = 3; b >= 0; b--) begin
				code[b] = 1'b1;
				op(0, 1, 8'h02, {4'h0, code});
				repeat (2) @(posedge sys_clk_i);
				op(1, 0, 8'h21, 8'h00);
				chk(rfd[3:1], 8'(c), "select");
				if (!rfd[0]) code[b] = 1'b0;
			end
			chk(code, 8'((e + 2) / 4 > 15 ? 15 : (e + 2) / 4), "result");
			m = (c >= 2 && c <= 5) ? ~(4'h1 << (c - 2)) : 4'hf;
			chk(nn, 8'(c == 6), "no pin");
			chk(pde, m, "pull-down");
			chk({pcr, pdr}, {pc & (c != 1), pd & m}, "port read");
		end
		$display("test convert done");
		wrap_up();
	end
endmodule : sar_adc_control_logic_tb
